// [logic/tpm_interpreter.sv]
// Function
// - auto repeat off: no key repeats
// - send once, repeat 30 Hz (15 Hz at slow baud) after half second
// - autowrap picks overwrite or next line
// - cursor keys application only with keypad+ANSI
// - column mode selects 80 or 132 columns
// - double width line holds half the columns
// - hash 3/4 mark double height halves
// - single line widened loses right half
// - cursor kept, clamped to right margin
// - hash 6 makes line double width
// - escape 1 routes stream to graphics
// - hash 7 starts hardcopy, holds updates
// - escape Z answers like device attributes
// - interlace selects 240 or 480 scan lines
// - keypad application or numeric mode select
// - load leds: 0 clears, 1-4 light
// - origin reset: screen origin, clamped to line 24
// - origin set: margin origin, clamped inside
// - origin change homes cursor, 1-based numbering
// - escape 8 restores saved cursor state
// - parameter report sequence ends in x
// - compat mode limits executed functions
// - escape, intermediates, then final ends
// - zero or empty parameter means default
`timescale 1ns/1ps
`default_nettype none
`include "tpm_defines.svh"
module tpm_interpreter #(
  parameter int unsigned REPEAT_DELAY_CYC  = `TPM_REPEAT_DELAY_CYC,
  parameter int unsigned REPEAT_PERIOD_CYC = `TPM_REPEAT_PERIOD_CYC
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // host character stream
  input  wire logic [7:0] rxData,
  input  wire logic       rxValid,
  output logic            rxReady,
  // installed options
  input  wire logic       gfxInstalled,
  input  wire logic       hcInstalled,
  input  wire logic       hcDone,
  // display state
  input  wire logic [7:0] cursorCol,
  input  wire logic       cursorAtMargin,
  input  wire logic       lineIsSingle,
  input  wire logic [5:0] topMargin,
  input  wire logic [5:0] bottomMargin,
  input  wire logic       posReq,
  input  wire logic [5:0] posLineIn,
  // keyboard
  input  wire logic       keyDown,
  input  wire logic [7:0] keyCode,
  input  wire logic       keyExempt,
  input  wire logic       ctrlHeld,
  input  wire logic       slowBaud,
  output logic            keySendValid,
  output logic [7:0]      keySendCode,
  output logic            keypadApp,
  output logic            cursorKeyApp,
  output logic [3:0]      leds,
  // modes
  output logic            autoRepeatMode,
  output logic            autowrapMode,
  output logic            originMode,
  output logic            ansiCompatMode,
  output logic [7:0]      maxCols,
  output logic [7:0]      dwLineCols,
  output logic [8:0]      scanLines,
  // printable characters
  output logic            charValid,
  output logic [7:0]      charData,
  output logic            charWrapNext,
  // line attributes
  output logic            lineAttrValid,
  output logic [1:0]      lineAttr,
  output logic            lineDiscardRight,
  output logic [7:0]      lineCursorCol,
  // cursor requests
  output logic            homeValid,
  output logic [5:0]      homeLine,
  output logic            posValid,
  output logic [5:0]      posLine,
  output logic            restoreCursor,
  // answers and options
  output logic            identifyReq,
  output logic            reportReq,
  output logic [7:0]      reportSol,
  output logic            gfxValid,
  output logic [7:0]      gfxData,
  output logic            hcStart,
  output logic            updateHold
);

  tpm_pkg::tpm_main_s s;
  tpm_pkg::tpm_main_s n;
  tpm_key_if          kif ();
  logic [7:0]         b;
  logic [7:0]         half;
  logic [5:0]         req;

  function automatic logic inRange(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
    inRange = (v >= lo) && (v <= hi);
  endfunction

  function automatic tpm_pkg::tpm_mode_t modeBit(input logic [7:0] p);
    modeBit = '0;
    case (p)
      `TPM_P_CKM:  modeBit[`TPM_M_CKM]  = 1'b1;
      `TPM_P_ANM:  modeBit[`TPM_M_ANM]  = 1'b1;
      `TPM_P_COLM: modeBit[`TPM_M_COLM] = 1'b1;
      `TPM_P_OM:   modeBit[`TPM_M_OM]   = 1'b1;
      `TPM_P_AWM:  modeBit[`TPM_M_AWM]  = 1'b1;
      `TPM_P_ARM:  modeBit[`TPM_M_ARM]  = 1'b1;
      `TPM_P_INLM: modeBit[`TPM_M_INLM] = 1'b1;
      default:     modeBit = '0;
    endcase
  endfunction

  // close one parameter: collect mode bits and led changes in turn
  function automatic tpm_pkg::tpm_main_s closeParam(input tpm_pkg::tpm_main_s c);
    tpm_pkg::tpm_mode_t m;
    closeParam = c;
    m = modeBit(c.pVal);
    if (!c.pFirstSeen) begin
      closeParam.pFirst = c.pVal;
      closeParam.pFirstSeen = 1'b1;
    end
    if (c.priv) begin
      if (m == '0) begin
        closeParam.pBad = 1'b1;
      end
      closeParam.modeMask = c.modeMask | m;
    end else if (c.pVal == 8'h00) begin
      closeParam.ledAcc = 4'h0;
    end else if (c.pVal <= `TPM_P_LEDMAX) begin
      closeParam.ledAcc = c.ledAcc | (4'h1 << (c.pVal[1:0] - 2'h1));
    end else begin
      closeParam.pBad = 1'b1;
    end
    closeParam.pVal = 8'h00;
  endfunction

  always_comb begin
    n = s;
    b = rxData;
    n.charValid = 1'b0;
    n.lineValid = 1'b0;
    n.homeValid = 1'b0;
    n.posValid  = 1'b0;
    n.restore   = 1'b0;
    n.identify  = 1'b0;
    n.reportReq = 1'b0;
    n.gfxValid  = 1'b0;
    n.hcStart   = 1'b0;
    half = s.dwCols;
    req = (posLineIn == 6'h00) ? 6'h01 : posLineIn;
    if (s.hold && hcDone) begin
      n.hold = 1'b0;
    end
    if (rxValid && s.rxReady) begin
      case (s.st)
        tpm_pkg::TPM_IDLE: begin
          if (b == `TPM_CH_ESC) begin
            n.st = tpm_pkg::TPM_ESC;
          end else if (inRange(b, `TPM_CH_PRINT_LO, `TPM_CH_PRINT_HI)) begin
            n.charValid = 1'b1;
            n.charData = b;
            n.wrapNext = s.modes[`TPM_M_AWM] && cursorAtMargin;
          end
        end
        tpm_pkg::TPM_ESC: begin
          n.st = tpm_pkg::TPM_IDLE;
          n.hashOnly = 1'b0;
          if (b == `TPM_CH_ESC) begin
            n.st = tpm_pkg::TPM_ESC;
          end else if (b == `TPM_CH_LBRK && s.modes[`TPM_M_ANM]) begin
            n.st = tpm_pkg::TPM_CSI;
            n.priv = 1'b0;
            n.pBad = 1'b0;
            n.pAny = 1'b0;
            n.pVal = 8'h00;
            n.pFirst = 8'h00;
            n.pFirstSeen = 1'b0;
            n.modeMask = '0;
            n.ledAcc = s.leds;
          end else if (inRange(b, `TPM_INTER_LO, `TPM_INTER_HI)) begin
            n.st = tpm_pkg::TPM_INTER;
            n.hashOnly = (b == `TPM_CH_HASH) && s.modes[`TPM_M_ANM];
          end else if (b < `TPM_INTER_LO) begin
            n.st = tpm_pkg::TPM_ESC;
          end else begin
            case (b)
              `TPM_F_KP_APP: n.kpApp = 1'b1;
              `TPM_F_KP_NUM: n.kpApp = 1'b0;
              `TPM_F_IDENT: n.identify = 1'b1;
              `TPM_F_ANSI: n.modes[`TPM_M_ANM] = 1'b1;
              `TPM_F_GFX_ON: begin
                if (gfxInstalled && s.modes[`TPM_M_ANM]) begin
                  n.st = tpm_pkg::TPM_GFX;
                end
              end
              `TPM_F_RESTORE: n.restore = s.modes[`TPM_M_ANM];
              default: n.st = tpm_pkg::TPM_IDLE;
            endcase
          end
        end
        tpm_pkg::TPM_INTER: begin
          if (b == `TPM_CH_ESC) begin
            n.st = tpm_pkg::TPM_ESC;
          end else if (inRange(b, `TPM_INTER_LO, `TPM_INTER_HI)) begin
            n.hashOnly = 1'b0;
          end else if (inRange(b, `TPM_FINAL_LO, `TPM_FINAL_HI)) begin
            n.st = tpm_pkg::TPM_IDLE;
            if (s.hashOnly) begin
              case (b)
                `TPM_F_DH_TOP: begin
                  n.lineValid = 1'b1;
                  n.lineAttr = tpm_pkg::TPM_LN_DTOP;
                end
                `TPM_F_DH_BOT: begin
                  n.lineValid = 1'b1;
                  n.lineAttr = tpm_pkg::TPM_LN_DBOT;
                end
                `TPM_F_DWIDTH: begin
                  n.lineValid = 1'b1;
                  n.lineAttr = tpm_pkg::TPM_LN_DWIDTH;
                end
                `TPM_F_HCOPY: begin
                  if (hcInstalled) begin
                    n.hcStart = 1'b1;
                    n.hold = 1'b1;
                  end
                end
                default: n.st = tpm_pkg::TPM_IDLE;
              endcase
              n.lineDiscard = lineIsSingle;
              n.lineCol = (cursorCol >= half) ? half - 8'h01 : cursorCol;
            end
          end
        end
        tpm_pkg::TPM_CSI: begin
          if (b == `TPM_CH_ESC) begin
            n.st = tpm_pkg::TPM_ESC;
          end else if (inRange(b, `TPM_FINAL_LO, `TPM_DIGIT_HI)) begin
            n.pAny = 1'b1;
            if ({s.pVal, b} > 16'h1935) begin
              n.pVal = `TPM_PVAL_MAX;
            end else begin
              n.pVal = 8'((s.pVal * 8'h0A) + (b - `TPM_FINAL_LO));
            end
          end else if (b == `TPM_CH_SEMI) begin
            n = closeParam(n);
          end else if (b == `TPM_CH_QMARK && !s.pAny && !s.pFirstSeen) begin
            n.priv = 1'b1;
          end else if (inRange(b, `TPM_PARAM_LO, `TPM_PARAM_HI)) begin
            n.pBad = 1'b1;
          end else if (inRange(b, `TPM_INTER_LO, `TPM_INTER_HI)) begin
            n.pBad = 1'b1;
          end else if (inRange(b, `TPM_CSI_FIN_LO, `TPM_FINAL_HI)) begin
            n = closeParam(n);
            n.st = tpm_pkg::TPM_IDLE;
            if (!n.pBad) begin
              case (b)
                `TPM_F_SET: begin
                  if (s.priv) begin
                    n.modes = s.modes | n.modeMask;
                    n.homeValid = n.modeMask[`TPM_M_OM];
                  end
                end
                `TPM_F_RESET: begin
                  if (s.priv) begin
                    n.modes = s.modes & ~n.modeMask;
                    n.homeValid = n.modeMask[`TPM_M_OM];
                  end
                end
                `TPM_F_LEDS: begin
                  if (!s.priv) begin
                    n.leds = n.ledAcc;
                  end
                end
                `TPM_F_DEVATTR: begin
                  n.identify = !s.priv && (n.pFirst == 8'h00);
                end
                `TPM_F_PARMREQ: begin
                  if (!s.priv) begin
                    n.reportReq = 1'b1;
                    n.reportSol = n.pFirst;
                  end
                end
                default: n.st = tpm_pkg::TPM_IDLE;
              endcase
            end
          end
        end
        tpm_pkg::TPM_GFX: begin
          n.gfxValid = 1'b1;
          n.gfxData = b;
          if (b == `TPM_CH_ESC) begin
            n.st = tpm_pkg::TPM_GFXESC;
          end
        end
        tpm_pkg::TPM_GFXESC: begin
          if (b == `TPM_F_GFX_OFF) begin
            n.st = tpm_pkg::TPM_IDLE;
          end else begin
            n.gfxValid = 1'b1;
            n.gfxData = b;
            n.st = (b == `TPM_CH_ESC) ? tpm_pkg::TPM_GFXESC : tpm_pkg::TPM_GFX;
          end
        end
        default: n.st = tpm_pkg::TPM_IDLE;
      endcase
    end
    // home position follows the new origin
    n.homeLine = n.modes[`TPM_M_OM] ? topMargin : 6'h01;
    if (posReq) begin
      n.posValid = 1'b1;
      if (n.modes[`TPM_M_OM]) begin
        n.posLine = (req - 6'h01 > bottomMargin - topMargin) ? bottomMargin : topMargin + req - 6'h01;
      end else begin
        n.posLine = (req > `TPM_SCREEN_LINES) ? `TPM_SCREEN_LINES : req;
      end
    end
    n.maxCols = n.modes[`TPM_M_COLM] ? `TPM_COLS_WIDE : `TPM_COLS_NARROW;
    n.dwCols = {1'b0, n.maxCols[7:1]};
    n.scanLines = n.modes[`TPM_M_INLM] ? `TPM_SCAN_INT : `TPM_SCAN_NONINT;
    n.ckApp = n.modes[`TPM_M_CKM] && n.kpApp && n.modes[`TPM_M_ANM];
    n.rxReady = !n.hold;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s <= '0;
      s.st <= tpm_pkg::TPM_IDLE;
      s.modes <= `TPM_RST_MODES;
      s.rxReady <= 1'b1;
      s.maxCols <= `TPM_COLS_NARROW;
      s.dwCols <= `TPM_COLS_NARROW >> 1;
      s.scanLines <= `TPM_SCAN_NONINT;
      s.homeLine <= 6'h01;
    end else begin
      s <= n;
    end
  end

  assign kif.keyDown   = keyDown;
  assign kif.keyCode   = keyCode;
  assign kif.keyExempt = keyExempt;
  assign kif.ctrlHeld  = ctrlHeld;
  assign kif.slowBaud  = slowBaud;
  assign kif.repeatOn  = s.modes[`TPM_M_ARM];

  tpm_key_repeat #(
    .DELAY_CYC  (REPEAT_DELAY_CYC),
    .PERIOD_CYC (REPEAT_PERIOD_CYC)
  ) u_repeat (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .kif     (kif.rep)
  );

  assign keySendValid     = kif.sendValid;
  assign keySendCode      = kif.sendCode;
  assign rxReady          = s.rxReady;
  assign keypadApp        = s.kpApp;
  assign cursorKeyApp     = s.ckApp;
  assign leds             = s.leds;
  assign autoRepeatMode   = s.modes[`TPM_M_ARM];
  assign autowrapMode     = s.modes[`TPM_M_AWM];
  assign originMode       = s.modes[`TPM_M_OM];
  assign ansiCompatMode   = s.modes[`TPM_M_ANM];
  assign maxCols          = s.maxCols;
  assign dwLineCols       = s.dwCols;
  assign scanLines        = s.scanLines;
  assign charValid        = s.charValid;
  assign charData         = s.charData;
  assign charWrapNext     = s.wrapNext;
  assign lineAttrValid    = s.lineValid;
  assign lineAttr         = s.lineAttr;
  assign lineDiscardRight = s.lineDiscard;
  assign lineCursorCol    = s.lineCol;
  assign homeValid        = s.homeValid;
  assign homeLine         = s.homeLine;
  assign posValid         = s.posValid;
  assign posLine          = s.posLine;
  assign restoreCursor    = s.restore;
  assign identifyReq      = s.identify;
  assign reportReq        = s.reportReq;
  assign reportSol        = s.reportSol;
  assign gfxValid         = s.gfxValid;
  assign gfxData          = s.gfxData;
  assign hcStart          = s.hcStart;
  assign updateHold       = s.hold;

endmodule
`default_nettype wire

// [common/tpm_defines.svh]
`ifndef TPM_DEFINES_SVH
`define TPM_DEFINES_SVH

// clock and timing
`define TPM_SYS_CLK_HZ        50000000
`define TPM_REPEAT_DELAY_MS   500
`define TPM_REPEAT_RATE_HZ    30
`define TPM_REPEAT_DELAY_CYC  ((`TPM_SYS_CLK_HZ / 1000) * `TPM_REPEAT_DELAY_MS)
`define TPM_REPEAT_PERIOD_CYC (`TPM_SYS_CLK_HZ / `TPM_REPEAT_RATE_HZ)

// character classes
`define TPM_CH_ESC      8'h1B
`define TPM_CH_HASH     8'h23
`define TPM_CH_LBRK     8'h5B
`define TPM_CH_SEMI     8'h3B
`define TPM_CH_QMARK    8'h3F
`define TPM_CH_PRINT_LO 8'h20
`define TPM_CH_PRINT_HI 8'h7E
`define TPM_INTER_LO    8'h20
`define TPM_INTER_HI    8'h2F
`define TPM_FINAL_LO    8'h30
`define TPM_FINAL_HI    8'h7E
`define TPM_PARAM_LO    8'h30
`define TPM_PARAM_HI    8'h3F
`define TPM_DIGIT_HI    8'h39
`define TPM_CSI_FIN_LO  8'h40

// final characters
`define TPM_F_GFX_ON    8'h31
`define TPM_F_GFX_OFF   8'h32
`define TPM_F_DH_TOP    8'h33
`define TPM_F_DH_BOT    8'h34
`define TPM_F_DWIDTH    8'h36
`define TPM_F_HCOPY     8'h37
`define TPM_F_RESTORE   8'h38
`define TPM_F_ANSI      8'h3C
`define TPM_F_KP_APP    8'h3D
`define TPM_F_KP_NUM    8'h3E
`define TPM_F_IDENT     8'h5A
`define TPM_F_SET       8'h68
`define TPM_F_RESET     8'h6C
`define TPM_F_LEDS      8'h71
`define TPM_F_DEVATTR   8'h63
`define TPM_F_PARMREQ   8'h78

// private mode parameter numbers
`define TPM_P_CKM  8'h01
`define TPM_P_ANM  8'h02
`define TPM_P_COLM 8'h03
`define TPM_P_OM   8'h06
`define TPM_P_AWM  8'h07
`define TPM_P_ARM  8'h08
`define TPM_P_INLM 8'h09
`define TPM_P_LEDMAX 8'h04

// mode vector bit positions
`define TPM_M_CKM  0
`define TPM_M_ANM  1
`define TPM_M_COLM 2
`define TPM_M_OM   3
`define TPM_M_AWM  4
`define TPM_M_ARM  5
`define TPM_M_INLM 6

// reset values and sizes
`define TPM_RST_MODES    7'h22
`define TPM_COLS_NARROW  8'h50
`define TPM_COLS_WIDE    8'h84
`define TPM_SCAN_NONINT  9'h0F0
`define TPM_SCAN_INT     9'h1E0
`define TPM_SCREEN_LINES 6'h18
`define TPM_PVAL_MAX     8'hFF

`endif

// [common/tpm_pkg.sv]
package tpm_pkg;

  typedef logic [6:0] tpm_mode_t;

  typedef enum logic [2:0] {
    TPM_IDLE   = 3'h0,
    TPM_ESC    = 3'h1,
    TPM_CSI    = 3'h3,
    TPM_INTER  = 3'h2,
    TPM_GFX    = 3'h6,
    TPM_GFXESC = 3'h7
  } tpm_state_e;

  typedef enum logic [1:0] {
    TPM_LN_SINGLE = 2'h0,
    TPM_LN_DWIDTH = 2'h1,
    TPM_LN_DTOP   = 2'h2,
    TPM_LN_DBOT   = 2'h3
  } tpm_line_e;

  typedef struct packed {
    tpm_state_e st;
    logic       hashOnly;
    logic       priv;
    logic       pBad;
    logic       pAny;
    logic [7:0] pVal;
    logic [7:0] pFirst;
    logic       pFirstSeen;
    tpm_mode_t  modeMask;
    logic [3:0] ledAcc;
    tpm_mode_t  modes;
    logic [3:0] leds;
    logic       kpApp;
    logic       ckApp;
    logic       hold;
    logic       rxReady;
    logic [7:0] maxCols;
    logic [7:0] dwCols;
    logic [8:0] scanLines;
    logic       charValid;
    logic [7:0] charData;
    logic       wrapNext;
    logic       lineValid;
    tpm_line_e  lineAttr;
    logic       lineDiscard;
    logic [7:0] lineCol;
    logic       homeValid;
    logic [5:0] homeLine;
    logic       posValid;
    logic [5:0] posLine;
    logic       restore;
    logic       identify;
    logic       reportReq;
    logic [7:0] reportSol;
    logic       gfxValid;
    logic [7:0] gfxData;
    logic       hcStart;
  } tpm_main_s;

  typedef struct packed {
    logic        held;
    logic        repeating;
    logic [25:0] cnt;
    logic        sendValid;
    logic [7:0]  sendCode;
  } tpm_rep_s;

endpackage

// [common/tpm_key_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface tpm_key_if;
  logic       keyDown;
  logic [7:0] keyCode;
  logic       keyExempt;
  logic       ctrlHeld;
  logic       slowBaud;
  logic       repeatOn;
  logic       sendValid;
  logic [7:0] sendCode;

  modport ctl (
    output keyDown, keyCode, keyExempt, ctrlHeld, slowBaud, repeatOn,
    input  sendValid, sendCode
  );
  modport rep (
    input  keyDown, keyCode, keyExempt, ctrlHeld, slowBaud, repeatOn,
    output sendValid, sendCode
  );
endinterface
`default_nettype wire

// [logic/tpm_key_repeat.sv]
`timescale 1ns/1ps
`default_nettype none
`include "tpm_defines.svh"
module tpm_key_repeat #(
  parameter int unsigned DELAY_CYC  = `TPM_REPEAT_DELAY_CYC,
  parameter int unsigned PERIOD_CYC = `TPM_REPEAT_PERIOD_CYC
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // keyboard side
  tpm_key_if.rep    kif
);

  tpm_pkg::tpm_rep_s s;
  tpm_pkg::tpm_rep_s n;
  logic [25:0]       limit;
  logic              mayRepeat;

  always_comb begin
    n = s;
    n.sendValid = 1'b0;
    mayRepeat = kif.repeatOn && !kif.keyExempt && !kif.ctrlHeld;
    if (!s.repeating) begin
      limit = 26'(DELAY_CYC);
    end else if (kif.slowBaud) begin
      limit = 26'(PERIOD_CYC * 2);
    end else begin
      limit = 26'(PERIOD_CYC);
    end
    if (!kif.keyDown) begin
      n.held = 1'b0;
      n.repeating = 1'b0;
      n.cnt = '0;
    end else if (!s.held) begin
      // first press always sends once, at once
      n.held = 1'b1;
      n.repeating = 1'b0;
      n.cnt = '0;
      n.sendValid = 1'b1;
      n.sendCode = kif.keyCode;
    end else if (mayRepeat) begin
      if (s.cnt >= limit - 26'h0000_001) begin
        n.cnt = '0;
        n.repeating = 1'b1;
        n.sendValid = 1'b1;
        n.sendCode = kif.keyCode;
      end else begin
        n.cnt = s.cnt + 26'h0000_001;
      end
    end else begin
      n.cnt = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign kif.sendValid = s.sendValid;
  assign kif.sendCode  = s.sendCode;

endmodule
`default_nettype wire

// [testbench/tpm_interpreter_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module tpm_interpreter_assertions (
  // clock and reset
  input wire logic       sys_clk, rst_n,
  // stimulus seen by the design
  input wire logic       keyDown, cursorAtMargin, lineIsSingle, gfxInstalled, hcInstalled,
  input wire logic [5:0] topMargin,
  // design outputs
  input wire logic       rxReady, keySendValid, keypadApp, cursorKeyApp, ansiCompatMode, autowrapMode, originMode,
  input wire logic       charValid, charWrapNext, lineAttrValid, lineDiscardRight, homeValid, gfxValid, hcStart,
  input wire logic       updateHold,
  input wire logic [7:0] maxCols, dwLineCols, lineCursorCol,
  input wire logic [8:0] scanLines,
  input wire logic [5:0] homeLine
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence press_s;
    keyDown && !$past(keyDown);
  endsequence
  sequence held_s;
    updateHold && !rxReady;
  endsequence
  column_range_a: assert property (maxCols == 8'h50 || maxCols == 8'h84)
    else $error("column limit invalid");
  half_width_a: assert property (dwLineCols == maxCols >> 1)
    else $error("double width count not half");
  scan_range_a: assert property (scanLines == 9'h0f0 || scanLines == 9'h1e0)
    else $error("scan line count invalid");
  cursor_key_a: assert property (cursorKeyApp |-> keypadApp && ansiCompatMode)
    else $error("cursor keys applied without keypad and ansi");
  key_press_a: assert property (press_s |=> keySendValid)
    else $error("key press not sent at once");
  wrap_choice_a: assert property (charValid |-> charWrapNext == ($past(autowrapMode) && $past(cursorAtMargin)))
    else $error("wrap choice wrong");
  home_line_a: assert property (homeValid |-> homeLine == (originMode ? $past(topMargin) : 6'h01))
    else $error("home line wrong");
  line_attr_a: assert property (lineAttrValid |-> lineDiscardRight == $past(lineIsSingle) && lineCursorCol < dwLineCols)
    else $error("line attribute side effects wrong");
  gfx_option_a: assert property (gfxValid |-> $past(gfxInstalled))
    else $error("graphics data without module");
  copy_hold_a: assert property (hcStart |-> $past(hcInstalled) ##1 held_s)
    else $error("hardcopy did not hold the stream");
endmodule
`default_nettype wire

// [testbench/tpm_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module tpm_host_model (
  // clock
  input  wire logic       sys_clk,
  // character stream
  input  wire logic       rxReady,
  output var logic [7:0]  rxData,
  output var logic        rxValid
);
  logic [7:0] q[$];
  logic       took = 1'b0;
  initial rxData = 8'h00;
  initial rxValid = 1'b0;
  always @(posedge sys_clk) took = rxValid && rxReady;
  // byte held until taken; idle data toggles
  always @(negedge sys_clk) begin
    if (!rxValid || took) begin
      rxValid <= q.size() != 0;
      rxData  <= q.size() != 0 ? q.pop_front() : ~rxData;
    end
  end
endmodule
`default_nettype wire

// [testbench/tpm_interpreter_test.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; $display("mismatch %0t %h %h", $time, (a), (b)); end end
bind tpm_interpreter tpm_interpreter_assertions u_tpm_interpreter_assertions (.*);
module tpm_interpreter_test;
  localparam logic [7:0] esc = 8'h1b;
  logic sys_clk = 1'b0;
  logic rst_n, rxValid, rxReady, gfxInstalled, hcInstalled, hcDone, cursorAtMargin, lineIsSingle, posReq;
  logic keyDown, keyExempt, ctrlHeld, slowBaud, keySendValid, keypadApp, cursorKeyApp, autoRepeatMode;
  logic autowrapMode, originMode, ansiCompatMode, charValid, charWrapNext, lineAttrValid, lineDiscardRight;
  logic homeValid, posValid, restoreCursor, identifyReq, reportReq, gfxValid, hcStart, updateHold;
  logic [7:0] rxData, cursorCol, keyCode, keySendCode, maxCols, dwLineCols, charData, lineCursorCol, reportSol, gfxData;
  logic [7:0] lastChar, lastKey, ch;
  logic [5:0] topMargin, bottomMargin, posLineIn, homeLine, posLine;
  logic [8:0] scanLines;
  logic [3:0] leds;
  logic [1:0] lineAttr, lastAttr;
  logic [31:0] rs = 32'hfe59_97e3;
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int md[10];
  int ev[6] = '{default: 0};
  int kx[5] = '{4, 1, 1, 3, 1};
  int pl[6] = '{1, 3, 6, 7, 8, 9};
  int i, v, p, w;

  tpm_interpreter #(.REPEAT_DELAY_CYC(20), .REPEAT_PERIOD_CYC(5)) u_tpm_interpreter (.*);
  tpm_host_model u_tpm_host_model (.*);

  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (++cyc > 20000) begin errors++; conclude(); end
  always @(posedge sys_clk) begin
    ev[0] += identifyReq;
    ev[1] += restoreCursor;
    ev[2] += gfxValid;
    ev[3] += keySendValid;
    ev[4] += hcStart;
    ev[5] += reportReq;
    if (charValid || gfxValid) lastChar = charValid ? charData : gfxData;
    if (lineAttrValid) lastAttr = lineAttr;
    if (keySendValid) lastKey = keySendCode;
  end

  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction

  task automatic conclude();
    if (errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic put(input logic [7:0] s[$]);
    int n = 0;
    foreach (s[k]) u_tpm_host_model.q.push_back(s[k]);
    while ((u_tpm_host_model.q.size() != 0 || rxValid) && n < 300) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 300) errors++;
    repeat (3) @(negedge sys_clk);
  endtask

  task automatic check_modes();
    `CHK(autoRepeatMode, md[8][0])
    `CHK(autowrapMode, md[7][0])
    `CHK(originMode, md[6][0])
    `CHK(ansiCompatMode, md[2][0])
    `CHK(maxCols, md[3] ? 8'h84 : 8'h50)
    `CHK(dwLineCols, md[3] ? 8'h42 : 8'h28)
    `CHK(scanLines, md[9] ? 9'h1e0 : 9'h0f0)
    `CHK(keypadApp, md[0][0])
    `CHK(cursorKeyApp, md[1][0] & md[0][0] & md[2][0])
    `CHK(leds, md[4][3:0])
  endtask

  initial begin
    rst_n = 1'b0;
    {gfxInstalled, hcInstalled, hcDone, cursorAtMargin, lineIsSingle, posReq} = '0;
    {keyDown, keyExempt, ctrlHeld, slowBaud} = '0;
    cursorCol = 8'h00;
    keyCode = 8'h41;
    topMargin = 6'h05;
    bottomMargin = 6'h0a;
    posLineIn = 6'h00;
    md = '{default: 0};
    md[2] = 1;
    md[8] = 1;
    repeat (16) @(negedge sys_clk);
    rst_n = 1'b1;
    check_modes();
    put('{esc, 8'h3d});
    md[0] = 1;
    for (i = 0; i < 18; i++) begin
      p = pl[i % 6];
      v = i < 6 ? 1 : i < 12 ? 0 : int'(rnd() & 1);
      cursorCol = 8'(rnd());
      {posReq, cursorAtMargin, lineIsSingle} = 3'(rnd());
      posLineIn = 6'(rnd());
      put('{esc, 8'h5b, 8'h3f, 8'(8'h30 + p), v ? 8'h68 : 8'h6c});
      md[p] = v;
      check_modes();
      w = md[6] ? topMargin : 1;
      p = md[6] ? bottomMargin : 24;
      w += posLineIn ? posLineIn - 1 : 0;
      if (posReq) `CHK({posValid, posLine}, {1'b1, 6'(w > p ? p : w)})
    end
    put('{esc, 8'h3e});
    md[0] = 0;
    check_modes();
    put('{esc, 8'h5b, 8'h31, 8'h3b, 8'h33, 8'h71});
    md[4] = 5;
    check_modes();
    put('{esc, 8'h5b, 8'h71});
    md[4] = 0;
    check_modes();
    v = int'(rnd() % 5);
    put('{esc, 8'h5b, 8'h34, 8'h3b, 8'h30, 8'h3b, 8'(8'h30 + v), 8'h71});
    md[4] = v ? 1 << (v - 1) : 0;
    check_modes();
    put('{esc, 8'h5b, 8'h35, 8'h71});
    put('{esc, 8'h5b, 8'h3f, 8'h35, 8'h68});
    check_modes();
    ch = 8'(8'h41 + rnd() % 26);
    put('{ch});
    `CHK(lastChar, ch)
    for (i = 0; i < 3; i++) begin
      cursorCol = 8'(rnd());
      lineIsSingle = rnd() & 1;
      put('{esc, 8'h23, i == 2 ? 8'h36 : 8'(8'h33 + i)});
      `CHK(lastAttr, i == 2 ? 2'h1 : 2'(i + 2))
    end
    put('{esc, 8'h5a, esc, 8'h5b, 8'h63, esc, 8'h38});
    `CHK(ev[0], 2)
    `CHK(ev[1], 1)
    put('{esc, 8'h5b, 8'h32, 8'h78});
    `CHK(ev[5] * 256 + reportSol, 32'h102)
    put('{esc, 8'h5b, 8'h3f, 8'h32, 8'h6c, esc, 8'h38, esc, 8'h5a});
    md[2] = 0;
    check_modes();
    `CHK(ev[0] * 2 + ev[1], 7)
    put('{esc, 8'h3c});
    md[2] = 1;
    check_modes();
    gfxInstalled = 1'b1;
    put('{esc, 8'h31, 8'h61, 8'h62, esc, 8'h32});
    `CHK(ev[2] * 256 + lastChar, 32'h31b)
    gfxInstalled = 1'b0;
    put('{esc, 8'h31, 8'h63});
    `CHK(ev[2] * 256 + lastChar, 32'h363)
    put('{esc, 8'h23, 8'h37});
    hcInstalled = 1'b1;
    put('{esc, 8'h23, 8'h37});
    `CHK(ev[4] * 2 + updateHold, 3)
    fork
      put('{8'h64});
      begin
        repeat (10) @(negedge sys_clk);
        `CHK(lastChar, 8'h63)
        hcDone = 1'b1;
        @(negedge sys_clk);
        hcDone = 1'b0;
      end
    join
    repeat (4) @(negedge sys_clk);
    `CHK({updateHold, lastChar}, 9'h064)
    put('{esc, 8'h5b, 8'h3f, 8'h38, 8'h68});
    for (i = 0; i < 5; i++) begin
      if (i == 4) put('{esc, 8'h5b, 8'h3f, 8'h38, 8'h6c});
      keyExempt = i == 1;
      ctrlHeld = i == 2;
      slowBaud = i == 3;
      keyCode = 8'(rnd());
      v = ev[3];
      keyDown = 1'b1;
      repeat (34) @(negedge sys_clk);
      keyDown = 1'b0;
      repeat (4) @(negedge sys_clk);
      `CHK(ev[3] - v, kx[i])
      `CHK(lastKey, keyCode)
    end
    conclude();
  end
endmodule
`default_nettype wire
